// File: src/sls_status_led.sv
`timescale 1ns/1ps
`default_nettype none
module sls_status_led #(
	parameter int unsigned TICK_CYC = sls_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire sls_pkg::sls_fault_t fault_in,
	input wire logic fault_reset,
	input wire logic temp_cool,
	input wire logic configured,
	input wire sls_pkg::sls_net_t net_in,
	output sls_pkg::sls_led_t power_status_indicator,
	output sls_pkg::sls_led_t module_led,
	output sls_pkg::sls_led_t network_led,
	output logic hist_we,
	output logic [2:0] hist_class,
	output logic [sls_pkg::DETAIL_W-1:0] hist_detail,
	output logic [$clog2(sls_pkg::HIST_DEPTH)-1:0] hist_count,
	output logic temp_lock
);
	localparam int CW = $clog2(TICK_CYC + 1);
	localparam int MW = 12;
	localparam int HW = $clog2(sls_pkg::HIST_DEPTH);
	typedef enum {SLS_ST_START, SLS_ST_WAIT, SLS_ST_RUN} sls_phase_t;
	typedef enum {SLS_P_IDLE, SLS_P_ON, SLS_P_OFF, SLS_P_PAUSE} sls_pwr_t;
	default clocking cb_sls @(posedge clk); endclocking
	default disable iff (rst);
	// millisecond tick
	logic [CW-1:0] tick_cnt_reg, tick_cnt_next;
	logic tick_reg, tick_next;
	always_comb begin
		tick_next = 1'b0;
		tick_cnt_next = tick_cnt_reg + CW'(1);
		if (tick_cnt_reg == CW'(TICK_CYC - 1)) begin
			tick_cnt_next = '0;
			tick_next = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_cnt_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			tick_cnt_reg <= tick_cnt_next;
			tick_reg <= tick_next;
		end
	end
	// slow blink and heartbeat counters in ms
	logic [MW-1:0] blink_ms_reg, blink_ms_next, hb_ms_reg, hb_ms_next;
	logic blink_reg, blink_next;
	always_comb begin
		blink_ms_next = blink_ms_reg;
		blink_next = blink_reg;
		hb_ms_next = hb_ms_reg;
		if (tick_reg) begin
			blink_ms_next = blink_ms_reg + MW'(1);
			if (blink_ms_reg == MW'(sls_pkg::BLINK_HALF_MS - 1)) begin
				blink_ms_next = '0;
				blink_next = ~blink_reg;
			end
			hb_ms_next = hb_ms_reg + MW'(1);
			if (hb_ms_reg == MW'(sls_pkg::HB_PERIOD_MS - 1)) begin
				hb_ms_next = '0;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			blink_ms_reg <= '0;
			blink_reg <= 1'b0;
			hb_ms_reg <= '0;
		end else begin
			blink_ms_reg <= blink_ms_next;
			blink_reg <= blink_next;
			hb_ms_reg <= hb_ms_next;
		end
	end
	// error register; only overtemperature is latched, and stays until cooled and fault reset
	logic [sls_pkg::ERR_BITS-1:0] err_reg, err_next, err_rise;
	logic [sls_pkg::ERR_BITS-1:0] flags_prev_reg;
	logic temp_lock_next;
	always_comb begin
		err_rise = fault_in.flags & ~flags_prev_reg;
		err_next = fault_in.flags;
		temp_lock_next = temp_lock;
		if (fault_reset && temp_cool) begin
			temp_lock_next = 1'b0;
		end
		if (fault_in.flags[sls_pkg::ERR_TEMP - 3'h1]) begin
			temp_lock_next = 1'b1; // set wins over reset
		end
		err_next[sls_pkg::ERR_TEMP - 3'h1] = temp_lock_next;
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			err_reg <= '0;
			flags_prev_reg <= '0;
			temp_lock <= 1'b0;
		end else begin
			err_reg <= err_next;
			flags_prev_reg <= fault_in.flags;
			temp_lock <= temp_lock_next;
		end
	end
	property p_temp_hold; temp_lock && !(fault_reset && temp_cool) |=> temp_lock; endproperty
	a_temp_hold: assert property (p_temp_hold) else $error("temp lock dropped");
	// lowest active class selects the flash count
	logic [2:0] err_class;
	logic [2:0] rise_class;
	always_comb begin
		err_class = sls_pkg::ERR_NONE;
		rise_class = sls_pkg::ERR_NONE;
		for (int i = sls_pkg::ERR_BITS - 1; i >= 0; i--) begin
			if (err_reg[i]) begin
				err_class = 3'(i + 1);
			end
			if (err_rise[i]) begin
				rise_class = 3'(i + 1);
			end
		end
	end
	// error history write port with detail code
	logic hist_we_next;
	logic [HW-1:0] hist_count_next;
	always_comb begin
		hist_we_next = |err_rise;
		hist_count_next = hist_count + (hist_we_next ? HW'(1) : HW'(0));
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			hist_we <= 1'b0;
			hist_class <= sls_pkg::ERR_NONE;
			hist_detail <= '0;
			hist_count <= '0;
		end else begin
			hist_we <= hist_we_next;
			hist_count <= hist_count_next;
			if (hist_we_next) begin
				hist_class <= rise_class;
				hist_detail <= fault_in.detail;
			end
		end
	end
	property p_hist_on_rise; (|err_rise) |=> hist_we; endproperty
	a_hist_on_rise: assert property (p_hist_on_rise) else $error("error not logged");
	// power indicator flash groups
	sls_pwr_t pwr_reg, pwr_next;
	logic [MW-1:0] pms_reg, pms_next;
	logic [2:0] pleft_reg, pleft_next;
	always_comb begin
		pwr_next = pwr_reg;
		pms_next = tick_reg ? pms_reg + MW'(1) : pms_reg;
		pleft_next = pleft_reg;
		case (pwr_reg)
			SLS_P_IDLE: begin
				pms_next = '0;
				if (err_class != sls_pkg::ERR_NONE) begin
					pwr_next = SLS_P_ON;
					pleft_next = err_class;
				end
			end
			SLS_P_ON: begin
				if (pms_reg == MW'(sls_pkg::FLASH_ON_MS)) begin
					pwr_next = SLS_P_OFF;
					pms_next = '0;
					pleft_next = pleft_reg - 3'h1;
				end
			end
			SLS_P_OFF: begin
				if (pms_reg == MW'(sls_pkg::FLASH_OFF_MS)) begin
					pms_next = '0;
					pwr_next = (pleft_reg == 3'h0) ? SLS_P_PAUSE : SLS_P_ON;
				end
			end
			SLS_P_PAUSE: begin
				if (pms_reg == MW'(sls_pkg::GROUP_PAUSE_MS)) begin
					pwr_next = SLS_P_IDLE; // repeats while error persists
				end
			end
			default: pwr_next = SLS_P_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr_reg <= SLS_P_IDLE;
			pms_reg <= '0;
			pleft_reg <= '0;
		end else begin
			pwr_reg <= pwr_next;
			pms_reg <= pms_next;
			pleft_reg <= pleft_next;
		end
	end
	// start-up sequence then wait for first connection
	sls_phase_t phase_reg, phase_next;
	logic [MW-1:0] sms_reg, sms_next;
	logic [2:0] sstep_reg, sstep_next;
	always_comb begin
		phase_next = phase_reg;
		sms_next = sms_reg;
		sstep_next = sstep_reg;
		case (phase_reg)
			SLS_ST_START: begin
				if (tick_reg) begin
					sms_next = sms_reg + MW'(1);
					if (sms_reg == MW'(sls_pkg::STARTUP_STEP_MS - 1)) begin
						sms_next = '0;
						sstep_next = sstep_reg + 3'h1;
						if (sstep_reg == 3'(sls_pkg::STARTUP_STEPS - 1)) begin
							phase_next = SLS_ST_WAIT;
						end
					end
				end
			end
			SLS_ST_WAIT: begin
				if (net_in.conn_any) begin
					phase_next = SLS_ST_RUN;
				end
			end
			SLS_ST_RUN: phase_next = SLS_ST_RUN;
			default: phase_next = SLS_ST_START;
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			phase_reg <= SLS_ST_START;
			sms_reg <= '0;
			sstep_reg <= '0;
		end else begin
			phase_reg <= phase_next;
			sms_reg <= sms_next;
			sstep_reg <= sstep_next;
		end
	end
	// owner timeout latch, cleared only when all owners are back
	logic eo_red_reg, eo_red_next;
	always_comb begin
		eo_red_next = eo_red_reg;
		if (net_in.eo_all_up) begin
			eo_red_next = 1'b0;
		end
		if (net_in.eo_timeout) begin
			eo_red_next = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			eo_red_reg <= 1'b0;
		end else begin
			eo_red_reg <= eo_red_next;
		end
	end
	property p_net_red_latch; eo_red_reg && !net_in.eo_all_up |=> eo_red_reg; endproperty
	a_net_red_latch: assert property (p_net_red_latch) else $error("red left early");
	property p_timeout_red; net_in.eo_timeout |=> eo_red_reg; endproperty
	a_timeout_red: assert property (p_timeout_red) else $error("timeout not latched");
	// indicator outputs
	sls_pkg::sls_led_t pwr_led_next, mod_led_next, net_led_next;
	always_comb begin
		pwr_led_next = '0;
		if (err_class != sls_pkg::ERR_NONE || pwr_reg != SLS_P_IDLE) begin
			pwr_led_next.red = (pwr_reg == SLS_P_ON);
		end else begin
			pwr_led_next.green = (hb_ms_reg < MW'(sls_pkg::HB_PULSE_MS));
		end
		mod_led_next = '0;
		net_led_next = '0;
		case (phase_reg)
			SLS_ST_START: begin
				mod_led_next = '{green: ~sstep_reg[0], red: sstep_reg[0]};
				net_led_next = mod_led_next;
			end
			SLS_ST_WAIT: begin
				mod_led_next.green = blink_reg;
				net_led_next.green = blink_reg;
			end
			default: begin
				mod_led_next.green = configured ? 1'b1 : blink_reg;
				if (!net_in.ip_configured) begin
					net_led_next = '0;
				end else if (eo_red_reg) begin
					net_led_next.red = blink_reg;
				end else if (net_in.conn_any) begin
					net_led_next.green = 1'b1;
				end else begin
					net_led_next.green = blink_reg;
				end
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			power_status_indicator <= '0;
			module_led <= '0;
			network_led <= '0;
		end else begin
			power_status_indicator <= pwr_led_next;
			module_led <= mod_led_next;
			network_led <= net_led_next;
		end
	end
	property p_red_when_err;
		err_class != sls_pkg::ERR_NONE |=> !power_status_indicator.green;
	endproperty
	a_red_when_err: assert property (p_red_when_err) else $error("green during error");
	property p_no_err_no_red;
		err_class == sls_pkg::ERR_NONE && pwr_reg == SLS_P_IDLE |=> !power_status_indicator.red;
	endproperty
	a_no_err_no_red: assert property (p_no_err_no_red) else $error("red without error");
	property p_net_off;
		phase_reg == SLS_ST_RUN && !net_in.ip_configured |=> network_led == '0;
	endproperty
	a_net_off: assert property (p_net_off) else $error("net led lit without ip");
	property p_mod_steady; phase_reg == SLS_ST_RUN && configured |=> module_led.green; endproperty
	a_mod_steady: assert property (p_mod_steady) else $error("module not green");
	property p_net_steady;
		phase_reg == SLS_ST_RUN && net_in.ip_configured && !eo_red_reg && net_in.conn_any
			|=> network_led.green && !network_led.red;
	endproperty
	a_net_steady: assert property (p_net_steady) else $error("net not steady green");
endmodule
`default_nettype wire

// File: src/sls_pkg.sv
package sls_pkg;
	// timing in ms, converted to 250 MHz cycles
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned TICK_US = 1000;
	localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;
	localparam int unsigned HB_PERIOD_MS = 1000;
	localparam int unsigned HB_PULSE_MS = 100;
	localparam int unsigned FLASH_ON_MS = 200;
	localparam int unsigned FLASH_OFF_MS = 300;
	localparam int unsigned GROUP_PAUSE_MS = 1500;
	localparam int unsigned BLINK_HALF_MS = 500;
	localparam int unsigned STARTUP_STEP_MS = 250;
	localparam int unsigned STARTUP_STEPS = 4;
	// error classes as flash counts
	localparam logic [2:0] ERR_NONE = 3'h0;
	localparam logic [2:0] ERR_GENERAL = 3'h1;
	localparam logic [2:0] ERR_VOLTAGE = 3'h2;
	localparam logic [2:0] ERR_TEMP = 3'h3;
	localparam logic [2:0] ERR_OVERCUR = 3'h4;
	localparam logic [2:0] ERR_CTRL = 3'h5;
	localparam logic [2:0] ERR_WDOG = 3'h6;
	localparam int ERR_BITS = 6;
	localparam int DETAIL_W = 16;
	localparam int HIST_DEPTH = 8;
	// bicolour indicator drive
	typedef struct packed {
		logic green;
		logic red;
	} sls_led_t;
	// fault inputs, one bit per class (bit0 = general)
	typedef struct packed {
		logic [ERR_BITS-1:0] flags;
		logic [DETAIL_W-1:0] detail;
	} sls_fault_t;
	// network stack status
	typedef struct packed {
		logic ip_configured;
		logic conn_any;
		logic eo_timeout;
		logic eo_all_up;
	} sls_net_t;
endpackage

// File: tb/sls_scanner.sv
`timescale 1ns/1ps
`default_nettype none
// far-side scanner: owns the connections and sends fault resets
module sls_scanner #(
	parameter int REUP_CYC = 3000
) (
	input wire logic clk,
	input wire logic [1:0] mode,
	input wire logic reset_req,
	output sls_pkg::sls_net_t net_out,
	output logic fault_reset
);
	int reup;
	// mode 0 no ip, 1 ip only, 2 connected, 3 owner timeout; owners return slowly
	always @(posedge clk) begin
		fault_reset <= reset_req;
		net_out.ip_configured <= (mode != 2'h0);
		net_out.conn_any <= (mode >= 2'h2);
		net_out.eo_timeout <= (mode == 2'h3);
		reup <= (mode == 2'h2) ? ((reup < REUP_CYC) ? reup + 1 : reup) : 0;
		net_out.eo_all_up <= (mode == 2'h2) && (reup == REUP_CYC);
	end
endmodule
`default_nettype wire

// File: tb/tb_status_led_signaling.sv
`timescale 1ns/1ps
`default_nettype none
module tb_status_led_signaling;
	localparam int T = 1;
	localparam int W = 1200 * T;
	logic clk, rst, temp_cool, configured, reset_req, fault_reset;
	logic [1:0] mode;
	sls_pkg::sls_fault_t fault_in;
	sls_pkg::sls_net_t net_in;
	sls_pkg::sls_led_t pwr, mod_led, net_led;
	logic hist_we, temp_lock;
	logic [2:0] hist_class, hist_count;
	logic [sls_pkg::DETAIL_W-1:0] hist_detail;
	int n_errors, n_tests, seed, exp_cnt, gon, ron, k, n;
	logic [18:0] log_q[$];

	sls_status_led #(.TICK_CYC(T)) i_sls_status_led (.clk(clk), .rst(rst),
		.fault_in(fault_in), .fault_reset(fault_reset), .temp_cool(temp_cool),
		.configured(configured), .net_in(net_in), .power_status_indicator(pwr),
		.module_led(mod_led), .network_led(net_led), .hist_we(hist_we),
		.hist_class(hist_class), .hist_detail(hist_detail),
		.hist_count(hist_count), .temp_lock(temp_lock));
	sls_scanner i_sls_scanner (.clk(clk), .mode(mode), .reset_req(reset_req),
		.net_out(net_in), .fault_reset(fault_reset));

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		if (n_errors == 0 && n_tests > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	// on-cycles of one indicator over a window; 0 module, 1 network, 2 power
	task automatic watch(input int sel, input int len);
		sls_pkg::sls_led_t v;
		gon = 0;
		ron = 0;
		repeat (len) begin
			@(posedge clk);
			#1;
			v = (sel == 0) ? mod_led : (sel == 1) ? net_led : pwr;
			gon += v.green;
			ron += v.red;
		end
		@(posedge clk);
	endtask
	// off, flashing or steady, two bits per colour
	function automatic logic [1:0] cls(input int c);
		return (c == 0) ? 2'h0 : (c == W) ? 2'h2 : 2'h1;
	endfunction
	task automatic pat(input int sel, input logic [3:0] exp);
		tick(10);
		watch(sel, W);
		chk({cls(gon), cls(ron)}, exp);
	endtask
	// raise faults, expect one log entry with the lowest class
	task automatic set_fault(input logic [5:0] f, input logic [2:0] c);
		logic [15:0] d;
		logic [18:0] e;
		int i;
		d = 16'($random(seed));
		fault_in <= {f, d};
		log_q.push_back({c, d});
		exp_cnt = (exp_cnt + 1) % 8;
		for (i = 0; i < 4 && hist_we !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		e = log_q.pop_front();
		chk({hist_we, hist_class, hist_detail}, {1'b1, e});
		chk(hist_count, exp_cnt);
		@(posedge clk);
		#1;
		chk(hist_we, 0);
		@(posedge clk);
	endtask
	// red flashes between two long dark gaps
	task automatic group(output int cnt);
		int gap, i;
		gap = 0;
		cnt = -1;
		for (i = 0; i < 12000 * T; i++) begin
			@(posedge clk);
			#1;
			if (pwr.red && gap > 0) begin
				if (gap >= 1000 * T && cnt >= 0) break;
				cnt = (gap >= 1000 * T) ? 1 : (cnt < 0) ? cnt : cnt + 1;
			end
			gap = pwr.red ? 0 : gap + 1;
		end
		@(posedge clk);
	endtask

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// hang guard
	initial begin
		#320000;
		n_errors++;
		close_out();
	end
	initial begin
		seed = 24144;
		n_errors = 0;
		n_tests = 0;
		exp_cnt = 0;
		rst = 1'b1;
		fault_in = '0;
		temp_cool = 1'b0;
		configured = 1'b0;
		mode = 2'h0;
		reset_req = 1'b0;
		tick(2);
		rst <= 1'b0;
		tick(1100 * T);
		pat(0, 4'h4);
		pat(1, 4'h4);
		mode <= 2'h2;
		pat(1, 4'h8);
		configured <= 1'b1;
		pat(0, 4'h8);
		configured <= 1'b0;
		pat(0, 4'h4);
		mode <= 2'h3;
		pat(1, 4'h1);
		mode <= 2'h2;
		pat(1, 4'h1);
		tick(2000);
		pat(1, 4'h8);
		mode <= 2'h1;
		pat(1, 4'h4);
		mode <= 2'h0;
		pat(1, 4'h0);
		// every class; class 3 raised together with class 4
		for (k = 1; k <= 6; k++) begin
			set_fault((k == 3) ? 6'h0c : 6'h01 << (k - 1), k[2:0]);
			group(n);
			chk(n, k);
			if (k == 3) begin
				fault_in.flags <= '0;
				reset_req <= 1'b1;
				tick(3);
				reset_req <= 1'b0;
				#1 chk(temp_lock, 1);
				tick(1);
				temp_cool <= 1'b1;
				reset_req <= 1'b1;
				tick(3);
				reset_req <= 1'b0;
				#1 chk(temp_lock, 0);
				tick(1);
			end
			fault_in.flags <= '0;
			tick(2);
		end
		tick(4600 * T);
		watch(2, 1000 * T);
		chk(gon, 100 * T);
		chk(ron, 0);
		close_out();
	end
endmodule
`default_nettype wire
